// ==== core/cps_defines.svh ====
// Offsets, field positions, reset values and cycle counts for the clock prescaler and sleep control.
// Assumes inclusion by bare name from the core files.
`ifndef CPS_DEFINES_SVH
`define CPS_DEFINES_SVH

// Register byte offsets
`define CPS_OFF_CLKDIV     8'h00
`define CPS_OFF_SLEEP      8'h04
`define CPS_OFF_STATUS     8'h08

// Divider control fields
`define CPS_UNLOCK_BIT     7
`define CPS_RSVD_BIT       6
`define CPS_TDIV_HI        5
`define CPS_TDIV_LO        3
`define CPS_SDIV_HI        2
`define CPS_SDIV_LO        0

// Sleep control fields
`define CPS_SMODE_HI       3
`define CPS_SMODE_LO       1
`define CPS_ARM_BIT        0

// Reset values
`define CPS_CLKDIV_RST     8'h00
`define CPS_SLEEP_RST      8'h00
`define CPS_SDIV_FUSE      3'h3
`define CPS_SDIV_NOFUSE    3'h0
`define CPS_TDIV_OFF       3'h0

// Sleep mode codes
`define CPS_MODE_IDLE      3'h0
`define CPS_MODE_NOISE     3'h1
`define CPS_MODE_PDOWN     3'h2

// Cycle counts
`define CPS_UNLOCK_CYCLES  3'h4
`define CPS_WAKE_HALT      3'h4
`define CPS_STARTUP_CYCLES 16

`endif

// ==== core/cps_pkg.sv ====
// Types shared by the clock prescaler and sleep control files.
// Assumes nothing of its surroundings.
package cps_pkg;

   typedef enum logic [2:0] {
      CPS_RUN,
      CPS_SLEEP,
      CPS_STARTUP,
      CPS_HALT
   } cps_state_t;

endpackage : cps_pkg

// ==== core/cps_unlock_timer.sv ====
// Timed unlock window for divider changes.
// Assumes start and close are one-cycle pulses on clock_i.
`timescale 1ns/1ps
`default_nettype none
`include "cps_defines.svh"

module cps_unlock_timer
   import cps_pkg::*;
(
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic rst_i,
   // Control
   input  wire logic start_i,
   input  wire logic close_i,
   // State
   output logic      open_o
);

   logic [2:0] count_reg;

   // Window open, closed by field write or timeout
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         open_o <= 1'b0;
      end else if (close_i) begin
         open_o <= 1'b0;
      end else if (start_i && !open_o) begin
         open_o <= 1'b1;
      end else if (open_o && count_reg == `CPS_UNLOCK_CYCLES - 3'h1) begin
         open_o <= 1'b0;
      end
   end

   // Cycles since the unlocking write
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         count_reg <= 3'h0;
      end else if (start_i && !open_o) begin
         count_reg <= 3'h0;
      end else if (open_o) begin
         count_reg <= count_reg + 3'h1;
      end
   end

endmodule : cps_unlock_timer
`default_nettype wire

// ==== core/cps_divider.sv ====
// Glitch-free power-of-two enable divider.
// Assumes clock_i is the undivided input clock.
`timescale 1ns/1ps
`default_nettype none
`include "cps_defines.svh"

module cps_divider
   import cps_pkg::*;
#(
   parameter int CW = 7
)(
   // Clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   // Setting
   input  wire logic [2:0] shift_i,
   input  wire logic       off_i,
   // Enable
   output logic            tick_o,
   output logic [2:0]      shift_o
);

   logic [CW-1:0] cnt_reg;
   logic          off_reg;
   logic [CW-1:0] big_mask;

   function automatic logic [CW-1:0] mask_of(input logic [2:0] sh);
      mask_of = CW'((1 << sh) - 1);
   endfunction : mask_of

   assign big_mask = mask_of(shift_i > shift_o ? shift_i : shift_o);

   // Free-running synchronous count
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + CW'(1);
      end
   end

   // Switch only at a boundary of the slower setting
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         shift_o <= 3'h0;
         off_reg <= 1'b1;
      end else if ((cnt_reg & big_mask) == big_mask) begin
         shift_o <= shift_i;
         off_reg <= off_i;
      end
   end

   // Enable pulse
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= !off_reg && ((cnt_reg & mask_of(shift_o)) == mask_of(shift_o));
      end
   end

endmodule : cps_divider
`default_nettype wire

// ==== core/cps_top.sv ====
// Clock prescaler and sleep control with an APB register slave.
// Assumes one clock, synchronous inputs and a core that pulses sleep_exec_i on the sleep instruction.
`timescale 1ns/1ps
`default_nettype none
`include "cps_defines.svh"

module cps_top
   import cps_pkg::*;
#(
   parameter int STARTUP_CYCLES = `CPS_STARTUP_CYCLES,
   parameter int DIV_WIDTH      = 7
)(
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Fuse and core
   input  wire logic        divide_by_eight_fuse_i,
   input  wire logic        sleep_exec_i,
   // Wake sources
   input  wire logic        irq_wake_i,
   input  wire logic        async_wake_i,
   input  wire logic        timer_two_event_i,
   input  wire logic        timer_three_event_i,
   input  wire logic        timer_two_irq_mask_i,
   input  wire logic        timer_three_irq_mask_i,
   input  wire logic        global_irq_en_i,
   // Clock enables
   output logic             cpu_clk_en_o,
   output logic             flash_clk_en_o,
   output logic             io_clk_en_o,
   output logic             timer_clock_out_o,
   output logic             fast_rc_oscillator_run_o,
   // Core control
   output logic             core_halt_o,
   output logic             irq_resume_o
);

   // Register state
   logic [2:0]   system_divider_select_reg;
   logic [2:0]   timer_divider_select_reg;
   logic [2:0]   sleep_mode_select_reg;
   logic         sleep_arm_reg;
   logic         fuse_done_reg;
   logic         divider_change_unlock;
   cps_state_t   state_reg;
   logic [2:0]   sleep_mode_reg;
   logic [15:0]  startup_cnt_reg;
   logic [2:0]   halt_cnt_reg;

   // Bus decode
   logic         access;
   logic         wr_fire;
   logic         hit_div;
   logic         hit_sleep;
   logic         hit_status;
   logic         mapped;
   logic [7:0]   wbyte;
   logic         unlock_write;
   logic         field_write;
   logic [7:0]   div_rdata;
   logic [7:0]   sleep_rdata;
   logic [7:0]   status_rdata;

   // Divider outputs
   logic         sys_tick;
   logic         tmr_tick;
   logic [2:0]   sys_shift_applied;
   logic [2:0]   tmr_shift_applied;
   logic [2:0]   tmr_shift;
   logic         tmr_off;

   // Wake decode
   logic         timer_wake;
   logic         wake_now;
   logic         mode_valid;

   assign access     = psel_i && penable_i;
   assign wr_fire    = access && pready_o && pwrite_i;
   assign hit_div    = paddr_i == `CPS_OFF_CLKDIV;
   assign hit_sleep  = paddr_i == `CPS_OFF_SLEEP;
   assign hit_status = paddr_i == `CPS_OFF_STATUS;
   assign mapped     = hit_div || hit_sleep || hit_status;
   assign wbyte      = pwdata_i[7:0];

   assign unlock_write = wr_fire && hit_div && wbyte == 8'h80;
   assign field_write  = wr_fire && hit_div && !unlock_write && divider_change_unlock;

   assign div_rdata = {divider_change_unlock,
                       1'b0,
                       timer_divider_select_reg,
                       system_divider_select_reg};

   assign sleep_rdata = {4'h0,
                         sleep_mode_select_reg,
                         sleep_arm_reg};

   assign status_rdata = {tmr_shift_applied,
                          sys_shift_applied,
                          state_reg != CPS_RUN,
                          core_halt_o};

   // Unlock window
   cps_unlock_timer u_unlock (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .start_i (unlock_write),
      .close_i (field_write),
      .open_o  (divider_change_unlock)
   );

   // APB handshake, one wait state
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
      end else begin
         pready_o <= access && !pready_o;
      end
   end

   // Error flag for unmapped addresses
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pslverr_o <= 1'b0;
      end else begin
         pslverr_o <= access && !pready_o && !mapped;
      end
   end

   // Read data
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (access && !pready_o && !pwrite_i) begin
         unique case (1'b1)
            hit_div:    prdata_o <= {24'h00_0000, div_rdata};
            hit_sleep:  prdata_o <= {24'h00_0000, sleep_rdata};
            hit_status: prdata_o <= {24'h00_0000, status_rdata};
            default:    prdata_o <= 32'h0000_0000;
         endcase
      end else begin
         prdata_o <= 32'h0000_0000;
      end
   end

   // System divider field with fuse load after reset release
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         system_divider_select_reg <= `CPS_SDIV_NOFUSE;
         fuse_done_reg             <= 1'b0;
      end else if (!fuse_done_reg) begin
         fuse_done_reg             <= 1'b1;
         system_divider_select_reg <= divide_by_eight_fuse_i ? `CPS_SDIV_FUSE : `CPS_SDIV_NOFUSE;
      end else if (field_write) begin
         system_divider_select_reg <= wbyte[`CPS_SDIV_HI:`CPS_SDIV_LO];
      end
   end

   // Timer divider field
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         timer_divider_select_reg <= `CPS_TDIV_OFF;
      end else if (field_write) begin
         timer_divider_select_reg <= wbyte[`CPS_TDIV_HI:`CPS_TDIV_LO];
      end
   end

   // Sleep control register
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sleep_mode_select_reg <= 3'(`CPS_SLEEP_RST >> `CPS_SMODE_LO);
         sleep_arm_reg         <= 1'b0;
      end else if (wr_fire && hit_sleep) begin
         sleep_mode_select_reg <= wbyte[`CPS_SMODE_HI:`CPS_SMODE_LO];
         sleep_arm_reg         <= wbyte[`CPS_ARM_BIT];
      end
   end

   // Timer code 000 is off, others map to shift code minus one
   assign tmr_off   = timer_divider_select_reg == `CPS_TDIV_OFF;
   assign tmr_shift = tmr_off ? 3'h0 : timer_divider_select_reg - 3'h1;

   // System clock divider
   cps_divider #(
      .CW (DIV_WIDTH)
   ) u_sys_div (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .shift_i (system_divider_select_reg),
      .off_i   (1'b0),
      .tick_o  (sys_tick),
      .shift_o (sys_shift_applied)
   );

   // Timer clock divider
   cps_divider #(
      .CW (DIV_WIDTH)
   ) u_tmr_div (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .shift_i (tmr_shift),
      .off_i   (tmr_off),
      .tick_o  (tmr_tick),
      .shift_o (tmr_shift_applied)
   );

   // Mode decode and wake qualification
   assign mode_valid = sleep_mode_select_reg == `CPS_MODE_IDLE
                    || sleep_mode_select_reg == `CPS_MODE_NOISE
                    || sleep_mode_select_reg == `CPS_MODE_PDOWN;

   assign timer_wake = global_irq_en_i
                    && ((timer_two_event_i && timer_two_irq_mask_i)
                     || (timer_three_event_i && timer_three_irq_mask_i));

   always_comb begin
      wake_now = 1'b0;
      unique case (sleep_mode_reg)
         `CPS_MODE_IDLE:  wake_now = irq_wake_i;
         `CPS_MODE_NOISE: wake_now = irq_wake_i || timer_wake;
         `CPS_MODE_PDOWN: wake_now = async_wake_i;
         default:         wake_now = 1'b0;
      endcase
   end

   // Sleep sequencer; reset returns to run at the reset vector
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= CPS_RUN;
      end else begin
         unique case (state_reg)
            CPS_RUN: begin
               if (sleep_exec_i && sleep_arm_reg && mode_valid) begin
                  state_reg <= CPS_SLEEP;
               end
            end
            CPS_SLEEP: begin
               if (wake_now) begin
                  state_reg <= CPS_STARTUP;
               end
            end
            CPS_STARTUP: begin
               if (startup_cnt_reg == 16'h0000) begin
                  state_reg <= CPS_HALT;
               end
            end
            CPS_HALT: begin
               if (halt_cnt_reg == `CPS_WAKE_HALT - 3'h1) begin
                  state_reg <= CPS_RUN;
               end
            end
         endcase
      end
   end

   // Latched mode for the current sleep
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sleep_mode_reg <= `CPS_MODE_IDLE;
      end else if (state_reg == CPS_RUN && sleep_exec_i && sleep_arm_reg) begin
         sleep_mode_reg <= sleep_mode_select_reg;
      end
   end

   // Oscillator startup only after power-down
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         startup_cnt_reg <= 16'h0000;
      end else if (state_reg == CPS_SLEEP) begin
         startup_cnt_reg <= (sleep_mode_reg == `CPS_MODE_PDOWN) ? 16'(STARTUP_CYCLES) : 16'h0000;
      end else if (state_reg == CPS_STARTUP && startup_cnt_reg != 16'h0000) begin
         startup_cnt_reg <= startup_cnt_reg - 16'h0001;
      end
   end

   // Four-cycle halt after startup
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         halt_cnt_reg <= 3'h0;
      end else if (state_reg == CPS_HALT) begin
         halt_cnt_reg <= halt_cnt_reg + 3'h1;
      end else begin
         halt_cnt_reg <= 3'h0;
      end
   end

   // Core control outputs; no memory clear is ever issued here
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         core_halt_o  <= 1'b0;
         irq_resume_o <= 1'b0;
      end else begin
         core_halt_o  <= state_reg != CPS_RUN
                      && !(state_reg == CPS_HALT && halt_cnt_reg == `CPS_WAKE_HALT - 3'h1);
         irq_resume_o <= state_reg == CPS_HALT && halt_cnt_reg == `CPS_WAKE_HALT - 3'h1;
      end
   end

   // CPU and flash enables run only when awake
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cpu_clk_en_o   <= 1'b0;
         flash_clk_en_o <= 1'b0;
      end else begin
         cpu_clk_en_o   <= sys_tick && state_reg == CPS_RUN;
         flash_clk_en_o <= sys_tick && state_reg == CPS_RUN;
      end
   end

   // I/O enable stops in noise reduction and power-down
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         io_clk_en_o <= 1'b0;
      end else begin
         io_clk_en_o <= sys_tick && !(state_reg == CPS_SLEEP && sleep_mode_reg != `CPS_MODE_IDLE);
      end
   end

   // Timer clock and fast RC stop only in power-down
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         timer_clock_out_o        <= 1'b0;
         fast_rc_oscillator_run_o <= 1'b0;
      end else begin
         timer_clock_out_o        <= tmr_tick && !(state_reg == CPS_SLEEP && sleep_mode_reg == `CPS_MODE_PDOWN);
         fast_rc_oscillator_run_o <= !(state_reg == CPS_SLEEP && sleep_mode_reg == `CPS_MODE_PDOWN);
      end
   end

endmodule : cps_top
`default_nettype wire

// ==== tb/cps_props.sv ====
// Port checker for the clock prescaler and sleep control block.
// Assumes it is bound onto cps_top and shares its single clock and reset.
`timescale 1ns/1ps
`default_nettype none
module cps_props #(
   parameter int STARTUP_CYCLES = 16
)(
   // Clock and reset
   input wire logic        clock_i,
   input wire logic        rst_i,
   // APB slave
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   // Core and clocks
   input wire logic        sleep_exec_i,
   input wire logic        cpu_clk_en_o,
   input wire logic        flash_clk_en_o,
   input wire logic        io_clk_en_o,
   input wire logic        timer_clock_out_o,
   input wire logic        fast_rc_oscillator_run_o,
   input wire logic        core_halt_o,
   input wire logic        irq_resume_o
);
   logic       mapped;
   logic [1:0] up_reg;
   assign mapped = (paddr_i == 8'h00) || (paddr_i == 8'h04) || (paddr_i == 8'h08);
   // The fast oscillator stop check applies from three edges after reset release
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) up_reg <= 2'h0;
      else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence req_s; psel_i && penable_i && !pready_o; endsequence
   sequence ans_s; pready_o ##1 !pready_o; endsequence
   ready_wait_a: assert property (req_s |=> ans_s)
      else $error("answer not one cycle after request");
   read_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
      else $error("read data outside answer");
   upper_zero_a: assert property (prdata_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   decode_err_a: assert property (req_s |=> pslverr_o != $past(mapped))
      else $error("error response wrong for address");
   sleep_entry_a: assert property ($rose(core_halt_o) |-> $past(sleep_exec_i, 2))
      else $error("halt without sleep instruction");
   resume_fall_a: assert property ($fell(core_halt_o) |-> irq_resume_o || $past(irq_resume_o))
      else $error("halt released without resume");
   halt_time_a: assert property (irq_resume_o |-> $past(core_halt_o) && $past(core_halt_o, 2)
      && $past(core_halt_o, 3) && $past(core_halt_o, 4))
      else $error("resume before four halted cycles");
   cpu_stop_a: assert property (core_halt_o |-> !cpu_clk_en_o && !flash_clk_en_o)
      else $error("cpu clock runs while halted");
   pdown_stop_a: assert property (up_reg == 2'h3 && !fast_rc_oscillator_run_o |->
      core_halt_o && !timer_clock_out_o && !io_clk_en_o)
      else $error("clocks run with fast oscillator stopped");
endmodule : cps_props
bind cps_top cps_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk_u (.clock_i, .rst_i, .psel_i, .penable_i,
   .paddr_i, .prdata_o, .pready_o, .pslverr_o, .sleep_exec_i, .cpu_clk_en_o, .flash_clk_en_o, .io_clk_en_o,
   .timer_clock_out_o, .fast_rc_oscillator_run_o, .core_halt_o, .irq_resume_o);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the clock prescaler and sleep control block.
// Assumes cps_top with a short startup count and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cps_pkg::*;
   typedef struct packed { logic [31:0] d; logic e; } cps_exp_t;
   logic        clock_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   logic        divide_by_eight_fuse_i, sleep_exec_i, irq_wake_i, async_wake_i, global_irq_en_i;
   logic        timer_two_event_i, timer_three_event_i, timer_two_irq_mask_i, timer_three_irq_mask_i;
   logic        cpu_clk_en_o, flash_clk_en_o, io_clk_en_o, timer_clock_out_o, fast_rc_oscillator_run_o;
   logic        core_halt_o, irq_resume_o;
   logic [4:0]  clk_v;
   int          n_fail = 0;
   int          comparisons = 0;
   cps_exp_t    exp_q[$];
   assign clk_v = {cpu_clk_en_o, flash_clk_en_o, io_clk_en_o, timer_clock_out_o, fast_rc_oscillator_run_o};

   cps_top #(.STARTUP_CYCLES(2)) dut_u (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .divide_by_eight_fuse_i, .sleep_exec_i, .irq_wake_i,
      .async_wake_i, .timer_two_event_i, .timer_three_event_i, .timer_two_irq_mask_i, .timer_three_irq_mask_i,
      .global_irq_en_i, .cpu_clk_en_o, .flash_clk_en_o, .io_clk_en_o, .timer_clock_out_o,
      .fast_rc_oscillator_run_o, .core_halt_o, .irq_resume_o);

   task automatic print_verdict();
      if (n_fail == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic guard(input int k, input int lim);
      if (k >= lim) begin
         check("wait bound", 32'h0, 32'h1);
         print_verdict();
      end
   endtask : guard

   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
   endtask : step

   // Bus answers compared against the oldest note
   always @(posedge clock_i) begin
      cps_exp_t e;
      if (psel_i && penable_i && pready_o === 1'b1) begin
         e = exp_q.pop_front();
         check("read data", e.d, prdata_o);
         check("error response", {31'h0, e.e}, {31'h0, pslverr_o});
      end
   end

   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [7:0] x,
                      input logic er);
      int k;
      exp_q.push_back({24'h0, x, er});
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= {24'h0, d};
      @(posedge clock_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge clock_i);
         k++;
      end while (pready_o !== 1'b1 && k < 20);
      guard(k, 20);
      penable_i <= 1'b0;
   endtask : apb

   task automatic idle();
      psel_i <= 1'b0;
      @(posedge clock_i);
   endtask : idle

   task automatic activity(output logic [4:0] m);
      m = 5'h0;
      repeat (40) begin
         @(posedge clock_i);
         m = m | clk_v;
      end
   endtask : activity

   task automatic period(input int b, output int p);
      int k;
      k = 0;
      while (clk_v[b] !== 1'b1 && k < 300) begin
         @(posedge clock_i);
         k++;
      end
      @(posedge clock_i);
      p = 1;
      while (clk_v[b] !== 1'b1 && p < 300) begin
         @(posedge clock_i);
         p++;
      end
      guard(p, 300);
   endtask : period

   task automatic sleep_test(input logic [2:0] mode, input logic arm, input logic [4:0] act);
      logic [4:0] m;
      int         k;
      logic       r;
      apb(1'b1, 8'h04, {4'hF, mode, arm}, 8'h00, 1'b0);
      idle();
      sleep_exec_i <= 1'b1;
      @(posedge clock_i);
      sleep_exec_i <= 1'b0;
      step(3);
      activity(m);
      check("clock activity", {27'h0, act}, {27'h0, m});
      if (act != 5'h1F) begin
         r = 1'($urandom);
         {timer_two_event_i, timer_three_event_i, timer_two_irq_mask_i, timer_three_irq_mask_i} <= {r, !r, r, !r};
         step(8);
         check("halt held", 32'h1, {31'h0, core_halt_o});
         global_irq_en_i <= 1'b1;
         irq_wake_i <= (mode == 3'h0);
         async_wake_i <= (mode == 3'h2);
         k = 0;
         while (irq_resume_o !== 1'b1 && k < 60) begin
            @(posedge clock_i);
            k++;
         end
         guard(k, 60);
         {irq_wake_i, async_wake_i, timer_two_event_i, timer_three_event_i} <= 4'h0;
         {timer_two_irq_mask_i, timer_three_irq_mask_i, global_irq_en_i} <= 3'h0;
         step(2);
         check("halt released", 32'h0, {31'h0, core_halt_o});
      end
      apb(1'b0, 8'h04, 8'h00, {4'h0, mode, arm}, 1'b0);
      apb(1'b1, 8'h04, 8'h00, 8'h00, 1'b0);
      idle();
   endtask : sleep_test

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   initial begin
      logic [7:0] v;
      logic [4:0] m;
      int         p;
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, sleep_exec_i, irq_wake_i, async_wake_i} = '0;
      {timer_two_event_i, timer_three_event_i, timer_two_irq_mask_i, timer_three_irq_mask_i} = 4'h0;
      global_irq_en_i = 1'b0;
      divide_by_eight_fuse_i = 1'b1;
      rst_i = 1'b1;
      void'($urandom(48199));
      step(6);
      rst_i <= 1'b0;
      step(2);
      apb(1'b0, 8'h00, 8'h00, 8'h03, 1'b0);
      apb(1'b1, 8'h0C, 8'h5A, 8'h00, 1'b1);
      apb(1'b0, 8'h0C, 8'h00, 8'h00, 1'b1);
      apb(1'b1, 8'h00, 8'h81, 8'h00, 1'b0);
      apb(1'b1, 8'h00, 8'h15, 8'h00, 1'b0);
      apb(1'b0, 8'h00, 8'h00, 8'h03, 1'b0);
      apb(1'b1, 8'h00, 8'h80, 8'h00, 1'b0);
      apb(1'b0, 8'h00, 8'h00, 8'h83, 1'b0);
      apb(1'b0, 8'h00, 8'h00, 8'h03, 1'b0);
      apb(1'b1, 8'h00, 8'h80, 8'h00, 1'b0);
      apb(1'b1, 8'h00, 8'h80, 8'h00, 1'b0);
      apb(1'b0, 8'h00, 8'h00, 8'h03, 1'b0);
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'h7F : 8'($urandom) & 8'h7F;
         apb(1'b1, 8'h00, 8'h80, 8'h00, 1'b0);
         apb(1'b1, 8'h00, v, 8'h00, 1'b0);
         apb(1'b0, 8'h00, 8'h00, v & 8'h3F, 1'b0);
         idle();
         step(300);
         apb(1'b0, 8'h08, 8'h00, {((v[5:3] == 3'h0) ? 3'h0 : 3'(v[5:3] - 3'h1)), v[2:0], 2'h0}, 1'b0);
         idle();
         period(4, p);
         check("system period", 32'h1 << v[2:0], p);
         if (v[5:3] != 3'h0) begin
            period(1, p);
            check("timer period", 32'h1 << (v[5:3] - 3'h1), p);
         end else begin
            activity(m);
            check("timer off", 32'h0, {31'h0, m[1]});
         end
      end
      apb(1'b1, 8'h00, 8'h80, 8'h00, 1'b0);
      apb(1'b1, 8'h00, 8'h08, 8'h00, 1'b0);
      idle();
      step(300);
      sleep_test(3'h0, 1'b0, 5'h1F);
      for (int c = 3; c < 8; c++) sleep_test(3'(c), 1'b1, 5'h1F);
      sleep_test(3'h0, 1'b1, 5'h07);
      sleep_test(3'h1, 1'b1, 5'h03);
      sleep_test(3'h2, 1'b1, 5'h00);
      apb(1'b1, 8'h04, 8'h01, 8'h00, 1'b0);
      idle();
      sleep_exec_i <= 1'b1;
      @(posedge clock_i);
      sleep_exec_i <= 1'b0;
      step(4);
      check("asleep", 32'h1, {31'h0, core_halt_o});
      divide_by_eight_fuse_i <= 1'b0;
      rst_i <= 1'b1;
      step(2);
      rst_i <= 1'b0;
      step(2);
      check("reset wake", 32'h0, {31'h0, core_halt_o});
      apb(1'b0, 8'h00, 8'h00, 8'h00, 1'b0);
      apb(1'b0, 8'h04, 8'h00, 8'h00, 1'b0);
      idle();
      check("pending answers", 32'h0, exp_q.size());
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
